// file: bench/rre_report_asserts.sv
// Port-level concurrent checks for the recovery-required error reporter
`timescale 1ns/1ns
module rre_report_asserts #(
  parameter int NUM_LP     = 4,
  parameter int WINDOW_CYC = 16
) (
  // Clock and reset
  input wire logic                       clk_sys_i,
  input wire logic                       rstn_i,
  // Error and clear requests
  input wire logic                       err_valid_i,
  input rre_pkg::rre_kind_t              err_kind_i,
  input wire logic [$clog2(NUM_LP)-1:0]  err_lp_i,
  input wire logic [rre_pkg::ADDR_W-1:0] err_addr_i,
  input wire logic [rre_pkg::LSB_W-1:0]  err_addr_lsb_i,
  input wire logic                       bank_clear_i,
  // Observed outputs
  input rre_pkg::rre_status_t            bank_status_o,
  input wire logic [rre_pkg::ADDR_W-1:0] bank_location_o,
  input wire logic [rre_pkg::MODE_W-1:0] bank_aux_mode_o,
  input wire logic [rre_pkg::LSB_W-1:0]  bank_aux_lsb_o,
  input wire logic [NUM_LP-1:0]          restart_ip_ok_flag_o,
  input wire logic [NUM_LP-1:0]          error_ip_linked_flag_o,
  input wire logic [NUM_LP-1:0]          affected_o,
  input wire logic [NUM_LP-1:0]          error_broadcast_signal_o
);
  localparam int BC_DLY = WINDOW_CYC + 1;
  logic              tk;
  logic              fresh;
  logic [NUM_LP-1:0] oh;
  int                gap_q;
  assign tk    = err_valid_i && err_kind_i != rre_pkg::RRE_KIND_NONE;
  assign fresh = tk && (!bank_status_o.record_present_flag || bank_clear_i);
  assign oh    = {{(NUM_LP-1){1'b0}}, 1'b1} << err_lp_i;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  // Edges since the last taken error; a gap past one window means no window is open
  always_ff @(posedge clk_sys_i or negedge rstn_i)
    if (!rstn_i)
      gap_q <= BC_DLY;
    else if (tk)
      gap_q <= 1;
    else if (gap_q < BC_DLY)
      gap_q <= gap_q + 1;
  sequence s_quiet; tk && gap_q >= BC_DLY; endsequence
  sequence s_load; fresh && err_kind_i == rre_pkg::RRE_KIND_DATA_LOAD && affected_o == '0; endsequence
  sequence s_fetch; fresh && err_kind_i == rre_pkg::RRE_KIND_INSN_FETCH && affected_o == '0; endsequence
  a_load_record: assert property (s_load |=> bank_status_o == {9'h17B, 16'h0134})
    else $error("data load record wrong");
  a_fetch_record: assert property (s_fetch |=> bank_status_o == {9'h17B, 16'h0150})
    else $error("fetch record wrong");
  a_load_flags: assert property (s_load |=> restart_ip_ok_flag_o == ~$past(oh) && error_ip_linked_flag_o == $past(oh))
    else $error("data load global flags wrong");
  a_fetch_flags: assert property (s_fetch |=> restart_ip_ok_flag_o == ~$past(oh) && error_ip_linked_flag_o == '0)
    else $error("fetch global flags wrong");
  a_addr_logged: assert property (s_load or s_fetch |=> bank_location_o == $past(err_addr_i)
    && bank_aux_mode_o == 3'h2 && bank_aux_lsb_o == $past(err_addr_lsb_i)) else $error("address details wrong");
  a_fatal_mark: assert property (fresh && err_kind_i == rre_pkg::RRE_KIND_FATAL |=> bank_status_o[24:16] == 9'h164)
    else $error("unrecoverable mark wrong");
  a_record_kept: assert property (tk && bank_status_o.record_present_flag && !bank_clear_i
    |=> bank_status_o.lost_error_flag && $stable(bank_status_o.arch_error_code)) else $error("record not kept");
  a_bcast_time: assert property (s_quiet |-> ##BC_DLY error_broadcast_signal_o == '1)
    else $error("broadcast late or missing");
  a_affected_mark: assert property (tk |=> (affected_o & $past(oh)) == $past(oh))
    else $error("affected processor not marked");
  a_bcast_pulse: assert property (error_broadcast_signal_o != '0 |-> error_broadcast_signal_o == '1 ##1
    error_broadcast_signal_o == '0) else $error("broadcast not one full pulse");
endmodule : rre_report_asserts

// file: bench/rre_report_test.sv
// Self-checking bench for the recovery-required error reporter
`timescale 1ns/1ns
module rre_report_test;
  localparam int WIN = 4;
  logic                       clk_sys_i = 1'b0, rstn_i = 1'b0, err_valid_i = 1'b0, bank_clear_i = 1'b0;
  rre_pkg::rre_kind_t         err_kind_i = rre_pkg::RRE_KIND_NONE;
  logic [1:0]                 err_lp_i = 2'h0;
  logic [rre_pkg::ADDR_W-1:0] err_addr_i = '0, bank_location_o;
  logic [5:0]                 err_addr_lsb_i = 6'h00, bank_aux_lsb_o;
  logic [3:0]                 global_clear_i = 4'h0, restart_ip_ok_flag_o, error_ip_linked_flag_o, affected_o;
  logic [3:0]                 error_broadcast_signal_o, rs, lk;
  logic [2:0]                 bank_aux_mode_o;
  rre_pkg::rre_status_t       bank_status_o, st;
  logic [32:0]                exp_q[$], msk_q[$], prev = '0, last, obs, m;
  int                         err_total = 0, n_compared = 0, bc_n = 0, sev[4], rnd;
  rre_pkg::rre_kind_t         ks[3] = '{rre_pkg::RRE_KIND_DATA_LOAD, rre_pkg::RRE_KIND_INSN_FETCH, rre_pkg::RRE_KIND_FATAL};
  rre_report #(.NUM_LP(4), .WINDOW_CYC(WIN)) uut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .err_valid_i(err_valid_i),
    .err_kind_i(err_kind_i), .err_lp_i(err_lp_i), .err_addr_i(err_addr_i), .err_addr_lsb_i(err_addr_lsb_i),
    .bank_clear_i(bank_clear_i), .global_clear_i(global_clear_i), .bank_status_o(bank_status_o),
    .bank_location_o(bank_location_o), .bank_aux_mode_o(bank_aux_mode_o), .bank_aux_lsb_o(bank_aux_lsb_o),
    .restart_ip_ok_flag_o(restart_ip_ok_flag_o), .error_ip_linked_flag_o(error_ip_linked_flag_o),
    .affected_o(affected_o), .error_broadcast_signal_o(error_broadcast_signal_o));
  assign obs = {bank_status_o, restart_ip_ok_flag_o, error_ip_linked_flag_o};
  always #5 clk_sys_i = ~clk_sys_i;
  task automatic check(input logic [32:0] seen, input logic [32:0] want);
    n_compared++;
    if (seen !== want)
    begin
      err_total++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check
  task automatic summarize();
    if (err_total == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  // Only real changes are noted, so a silent merge must leave outputs untouched
  task automatic push(input logic [32:0] mk);
    if ({st, rs, lk} !== last)
    begin
      exp_q.push_back({st, rs, lk});
      msk_q.push_back(mk);
    end
    last = {st, rs, lk};
  endtask : push
  task automatic err(input rre_pkg::rre_kind_t k, input int lp);
    int r;
    @(negedge clk_sys_i);
    err_valid_i = 1'b1;
    err_kind_i = k;
    err_lp_i = 2'(lp);
    err_addr_i = 52'({$urandom, $urandom});
    err_addr_lsb_i = 6'($urandom_range(63));
    if (k == rre_pkg::RRE_KIND_NONE)
      return;
    r = k == rre_pkg::RRE_KIND_FATAL ? 3 : (k == rre_pkg::RRE_KIND_DATA_LOAD ? 2 : 1);
    if (st.record_present_flag)
      st.lost_error_flag = 1'b1;
    else
      st = r == 3 ? {9'h164, 16'h0000} : {9'h17B, r == 2 ? 16'h0134 : 16'h0150};
    for (int j = 0; j < 4; j++)
      if (j == lp && r >= sev[j])
      begin
        rs[j] = 1'b0;
        lk[j] = r == 2;
        sev[j] = r;
      end
      else if (sev[j] == 0)
      begin
        rs[j] = 1'b1;
        lk[j] = 1'b0;
      end
    // Flags after an unrecoverable error are left open, so only its marks are compared
    push(r == 3 ? {9'h164, 24'h00_0000} : 33'h1_FFFF_FFFF);
  endtask : err
  task automatic idle(input int n);
    @(negedge clk_sys_i);
    err_valid_i = 1'b0;
    bank_clear_i = 1'b0;
    global_clear_i = 4'h0;
    repeat (n) @(negedge clk_sys_i);
  endtask : idle
  task automatic clear();
    @(negedge clk_sys_i);
    bank_clear_i = 1'b1;
    global_clear_i = 4'hF;
    st = '0;
    rs = 4'h0;
    lk = 4'h0;
    sev = '{default: 0};
    push(33'h1_FFFF_FFFF);
  endtask : clear
  always @(negedge clk_sys_i)
  begin
    if (rstn_i && error_broadcast_signal_o !== 4'h0)
      bc_n++;
    if (rstn_i && obs !== prev)
    begin
      prev = obs;
      if (exp_q.size() == 0)
        check(obs, ~obs);
      else
      begin
        m = msk_q.pop_front();
        check(obs & m, exp_q.pop_front() & m);
      end
    end
  end
  initial
  begin
    rnd = $urandom(32'h4c2d);
    st = '0;
    rs = 4'h0;
    lk = 4'h0;
    last = '0;
    sev = '{default: 0};
    repeat (10) @(negedge clk_sys_i);
    rstn_i = 1'b1;
    err(rre_pkg::RRE_KIND_NONE, 0);
    idle(10);
    foreach (ks[i])
    begin
      err(ks[i], $urandom_range(3));
      idle(10);
      clear();
      idle(10);
    end
    err(rre_pkg::RRE_KIND_DATA_LOAD, 1);
    err(rre_pkg::RRE_KIND_INSN_FETCH, 2);
    err(rre_pkg::RRE_KIND_DATA_LOAD, 1);
    err(rre_pkg::RRE_KIND_INSN_FETCH, 1);
    idle(10);
    clear();
    idle(2);
    for (int i = 0; i < 10 && exp_q.size() > 0; i++)
      @(negedge clk_sys_i);
    if (exp_q.size() > 0)
      err_total++;
    check(33'(bc_n), 33'h0_0000_0004);
    summarize();
  end
endmodule : rre_report_test
bind rre_report rre_report_asserts #(.NUM_LP(NUM_LP), .WINDOW_CYC(WINDOW_CYC)) chk (.clk_sys_i(clk_sys_i),
  .rstn_i(rstn_i), .err_valid_i(err_valid_i), .err_kind_i(err_kind_i), .err_lp_i(err_lp_i), .err_addr_i(err_addr_i),
  .err_addr_lsb_i(err_addr_lsb_i), .bank_clear_i(bank_clear_i), .bank_status_o(bank_status_o),
  .bank_location_o(bank_location_o), .bank_aux_mode_o(bank_aux_mode_o), .bank_aux_lsb_o(bank_aux_lsb_o),
  .restart_ip_ok_flag_o(restart_ip_ok_flag_o), .error_ip_linked_flag_o(error_ip_linked_flag_o),
  .affected_o(affected_o), .error_broadcast_signal_o(error_broadcast_signal_o));

// file: core/rre_enc_if.sv
// Interface carrying the encoder request and its encoded record
`timescale 1ns/1ns
interface rre_enc_if;
  rre_pkg::rre_kind_t   kind;
  rre_pkg::rre_status_t status;
  logic                 restart_ip_ok;
  logic                 error_ip_linked;
  modport enc (input kind, output status, output restart_ip_ok, output error_ip_linked);
  modport user (output kind, input status, input restart_ip_ok, input error_ip_linked);
endinterface : rre_enc_if

// file: core/rre_encoder.sv
// Combinational encoder from error kind to status record and global flags
`timescale 1ns/1ns
module rre_encoder (
  rre_enc_if.enc e
);
  always_comb
  begin
    e.status          = '0;
    e.restart_ip_ok   = 1'b1;
    e.error_ip_linked = 1'b0;
    case (e.kind)
      rre_pkg::RRE_KIND_DATA_LOAD:
      begin
        e.status.arch_error_code = {3'h0, 1'b0, rre_pkg::CACHE_HIER_PFX,
                                    rre_pkg::REQ_DATA_RD, rre_pkg::TXN_DATA, rre_pkg::LEVEL_0};
        e.restart_ip_ok   = 1'b0;
        e.error_ip_linked = 1'b1;
      end
      rre_pkg::RRE_KIND_INSN_FETCH:
      begin
        e.status.arch_error_code = {3'h0, 1'b0, rre_pkg::CACHE_HIER_PFX,
                                    rre_pkg::REQ_INSN_FETCH, rre_pkg::TXN_INSN, rre_pkg::LEVEL_0};
        e.restart_ip_ok   = 1'b0;
        e.error_ip_linked = 1'b0;
      end
      rre_pkg::RRE_KIND_FATAL:
      begin
        e.restart_ip_ok   = 1'b0;
        e.error_ip_linked = 1'b0;
      end
      default:
      begin
        e.restart_ip_ok   = 1'b1;
      end
    endcase
    if (e.kind == rre_pkg::RRE_KIND_DATA_LOAD || e.kind == rre_pkg::RRE_KIND_INSN_FETCH)
    begin
      e.status.record_present_flag  = 1'b1;
      e.status.uncorrected_flag     = 1'b1;
      e.status.reporting_on_flag    = 1'b1;
      e.status.aux_info_logged_flag = 1'b1;
      e.status.location_logged_flag = 1'b1;
      e.status.notify_flag          = 1'b1;
      e.status.action_required_flag = 1'b1;
    end
    else if (e.kind == rre_pkg::RRE_KIND_FATAL)
    begin
      e.status.record_present_flag  = 1'b1;
      e.status.uncorrected_flag     = 1'b1;
      e.status.reporting_on_flag    = 1'b1;
      e.status.context_corrupt_flag = 1'b1;
    end
  end
endmodule : rre_encoder

// file: core/rre_pkg.sv
// Constants and types for the recovery-required error reporting block
// Overview of operation
// - Data-load consumption error reports code 0x134: request 0011, type data, level 0.
// - Instruction-fetch consumption error reports code 0x150: request 0101, type instruction, level 0.
// - Filter bit 12 of the compound code is zero for both kinds.
// - Status fields: present, uncorrected, reporting, aux, location, notify, action set; lost, corrupt clear.
// - Location and aux flags set; physical address details stored in location and aux registers.
// - Aux address mode reads physical 010b; LSB field gives lowest valid address bit.
// - Broadcast the error signal to every logical processor when such an error is raised.
// - Affected processor is the consumer; its bank holds the error record.
// - Data load: affected processor gets restart flag clear, linked flag set.
// - Instruction fetch: affected processor gets both restart and linked flags clear.
// - Observing, non-affected processors get restart flag set and linked flag clear.
// - Errors inside one detection window may merge into one broadcast event.
// - Merged errors leave global flags showing the most severe error on that processor.
// - Unrecoverable error sets present, uncorrected, context-corrupt and reporting-on.
package rre_pkg;

  localparam int         CODE_W        = 16;
  localparam int         ADDR_W        = 52;
  localparam int         LSB_W         = 6;
  localparam int         MODE_W        = 3;
  localparam int         WINDOW_CYC    = 16;
  localparam int         NUM_LP        = 4;

  localparam logic [3:0] REQ_DATA_RD   = 4'h3;
  localparam logic [3:0] REQ_INSN_FETCH = 4'h5;
  localparam logic [1:0] TXN_INSN      = 2'h0;
  localparam logic [1:0] TXN_DATA      = 2'h1;
  localparam logic [1:0] LEVEL_0       = 2'h0;
  localparam logic [3:0] CACHE_HIER_PFX = 4'h1;
  localparam int         FILTER_BIT    = 12;
  localparam logic [MODE_W-1:0] ADDR_MODE_PHYS = 3'h2;

  typedef enum logic [1:0] {
    RRE_KIND_NONE,
    RRE_KIND_DATA_LOAD,
    RRE_KIND_INSN_FETCH,
    RRE_KIND_FATAL
  } rre_kind_t;

  // Severity order used when merging: fatal > data load > fetch
  typedef struct packed {
    logic record_present_flag;
    logic lost_error_flag;
    logic uncorrected_flag;
    logic reporting_on_flag;
    logic aux_info_logged_flag;
    logic location_logged_flag;
    logic context_corrupt_flag;
    logic notify_flag;
    logic action_required_flag;
    logic [CODE_W-1:0] arch_error_code;
  } rre_status_t;

endpackage : rre_pkg

// file: core/rre_report.sv
// Recovery-required error reporter: one bank, per-processor global flags, broadcast
`timescale 1ns/1ns
module rre_report #(
  parameter int NUM_LP     = rre_pkg::NUM_LP,
  parameter int WINDOW_CYC = rre_pkg::WINDOW_CYC
) (
  // Clock and reset
  input  wire logic                            clk_sys_i,
  input  wire logic                            rstn_i,
  // Error detection, one pulse per consumption
  input  wire logic                            err_valid_i,
  input  rre_pkg::rre_kind_t                   err_kind_i,
  input  wire logic [$clog2(NUM_LP)-1:0]       err_lp_i,
  input  wire logic [rre_pkg::ADDR_W-1:0]      err_addr_i,
  input  wire logic [rre_pkg::LSB_W-1:0]       err_addr_lsb_i,
  // Software clear
  input  wire logic                            bank_clear_i,
  input  wire logic [NUM_LP-1:0]               global_clear_i,
  // Bank contents
  output rre_pkg::rre_status_t                 bank_status_o,
  output logic [rre_pkg::ADDR_W-1:0]           bank_location_o,
  output logic [rre_pkg::MODE_W-1:0]           bank_aux_mode_o,
  output logic [rre_pkg::LSB_W-1:0]            bank_aux_lsb_o,
  // Per-processor global flags and broadcast
  output logic [NUM_LP-1:0]                    restart_ip_ok_flag_o,
  output logic [NUM_LP-1:0]                    error_ip_linked_flag_o,
  output logic [NUM_LP-1:0]                    affected_o,
  output logic [NUM_LP-1:0]                    error_broadcast_signal_o
);

  localparam int CNT_W = $clog2(WINDOW_CYC + 1);

  rre_enc_if enc_bus ();
  assign enc_bus.kind = err_valid_i ? err_kind_i : rre_pkg::RRE_KIND_NONE;
  rre_encoder u_enc (
    .e (enc_bus)
  );

  function automatic logic [1:0] sev(input rre_pkg::rre_kind_t k);
    case (k)
      rre_pkg::RRE_KIND_FATAL:      sev = 2'h3;
      rre_pkg::RRE_KIND_DATA_LOAD:  sev = 2'h2;
      rre_pkg::RRE_KIND_INSN_FETCH: sev = 2'h1;
      default:                      sev = 2'h0;
    endcase
  endfunction : sev

  localparam int LP_W = $clog2(NUM_LP);

  typedef enum logic [0:0] {
    RRE_IDLE,
    RRE_WINDOW
  } rre_state_t;

  // Detection window group
  rre_state_t                 state_q;
  rre_state_t                 state_d;
  logic [CNT_W-1:0]           win_q;
  logic [CNT_W-1:0]           win_d;
  logic [NUM_LP-1:0]          bcast_q;
  logic [NUM_LP-1:0]          bcast_d;
  // Shared bank group
  rre_pkg::rre_status_t       status_q;
  rre_pkg::rre_status_t       status_d;
  logic [rre_pkg::ADDR_W-1:0] loc_q;
  logic [rre_pkg::ADDR_W-1:0] loc_d;
  logic [rre_pkg::MODE_W-1:0] mode_q;
  logic [rre_pkg::MODE_W-1:0] mode_d;
  logic [rre_pkg::LSB_W-1:0]  lsb_q;
  logic [rre_pkg::LSB_W-1:0]  lsb_d;
  // Per-processor global flag group
  logic [NUM_LP-1:0]          rst_ok_q;
  logic [NUM_LP-1:0]          rst_ok_d;
  logic [NUM_LP-1:0]          linked_q;
  logic [NUM_LP-1:0]          linked_d;
  logic [NUM_LP-1:0]          aff_q;
  logic [NUM_LP-1:0]          aff_d;
  logic [NUM_LP-1:0][1:0]     sev_q;
  logic [NUM_LP-1:0][1:0]     sev_d;
  logic                       new_err;

  assign new_err = err_valid_i && (err_kind_i != rre_pkg::RRE_KIND_NONE);

  // Bank record with its location and aux fields
  always_comb
  begin
    status_d = status_q;
    loc_d    = loc_q;
    mode_d   = mode_q;
    lsb_d    = lsb_q;
    if (bank_clear_i)
      status_d = '0;
    // Set wins over clear: a new record lands after the clear
    if (new_err && (!status_q.record_present_flag || bank_clear_i))
    begin
      status_d = enc_bus.status;
      loc_d    = err_addr_i;
      mode_d   = rre_pkg::ADDR_MODE_PHYS;
      lsb_d    = err_addr_lsb_i;
    end
    else if (new_err && status_q.record_present_flag)
    begin
      // Bank already holds a record; keep it, note the loss, and mark context corrupt for a fatal error
      status_d.lost_error_flag = 1'b1;
      if (err_kind_i == rre_pkg::RRE_KIND_FATAL)
        status_d.context_corrupt_flag = 1'b1;
    end
  end

  // Detection window; only an error seen while idle opens a new one
  always_comb
  begin
    state_d = state_q;
    win_d   = win_q;
    bcast_d = '0;
    case (state_q)
      RRE_IDLE:
      begin
        if (new_err)
        begin
          state_d = RRE_WINDOW;
          win_d   = CNT_W'(WINDOW_CYC - 1);
        end
      end
      RRE_WINDOW:
      begin
        // Errors in the window merge; a single broadcast closes it
        if (win_q == '0)
        begin
          state_d = RRE_IDLE;
          bcast_d = '1;
        end
        else
          win_d = win_q - CNT_W'(1);
      end
      default:
        state_d = RRE_IDLE;
    endcase
  end

  for (genvar g = 0; g < NUM_LP; g++)
  begin : g_lp
    always_comb
    begin
      rst_ok_d[g] = rst_ok_q[g];
      linked_d[g] = linked_q[g];
      aff_d[g]    = aff_q[g];
      sev_d[g]    = sev_q[g];
      if (global_clear_i[g])
      begin
        rst_ok_d[g] = 1'b0;
        linked_d[g] = 1'b0;
        aff_d[g]    = 1'b0;
        sev_d[g]    = 2'h0;
      end
      if (new_err)
      begin
        if (err_lp_i == LP_W'(g))
        begin
          if (sev(err_kind_i) >= sev_d[g])
          begin
            rst_ok_d[g] = enc_bus.restart_ip_ok;
            linked_d[g] = enc_bus.error_ip_linked;
            sev_d[g]    = sev(err_kind_i);
          end
          aff_d[g] = 1'b1;
        end
        else if (!aff_d[g])
        begin
          rst_ok_d[g] = 1'b1;
          linked_d[g] = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      state_q <= RRE_IDLE;
      win_q   <= '0;
      bcast_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      win_q   <= win_d;
      bcast_q <= bcast_d;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      status_q <= '0;
      loc_q    <= '0;
      mode_q   <= '0;
      lsb_q    <= '0;
    end
    else
    begin
      status_q <= status_d;
      loc_q    <= loc_d;
      mode_q   <= mode_d;
      lsb_q    <= lsb_d;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rst_ok_q <= '0;
      linked_q <= '0;
      aff_q    <= '0;
      sev_q    <= '0;
    end
    else
    begin
      rst_ok_q <= rst_ok_d;
      linked_q <= linked_d;
      aff_q    <= aff_d;
      sev_q    <= sev_d;
    end
  end

  assign bank_status_o            = status_q;
  assign bank_location_o          = loc_q;
  assign bank_aux_mode_o          = mode_q;
  assign bank_aux_lsb_o           = lsb_q;
  assign restart_ip_ok_flag_o     = rst_ok_q;
  assign error_ip_linked_flag_o   = linked_q;
  assign affected_o               = aff_q;
  assign error_broadcast_signal_o = bcast_q;

endmodule : rre_report
